// ===== design/timer_v_regs.vh
// register map, field positions, reset values and codes of the compare timer
//
// Contract
// - a bus write takes effect in the data phase, the write's third state.
// - a counter clear in the write state wins; the written count is dropped.
// - a count step in the write state is lost; the written value loads.
// - a match during a compare constant write is suppressed; the write completes.
// - simultaneous matches: toggle beats set, set beats clear.
// - internal clock counts on falling edge of the selected divided clock.
// - switching between clock sources may add one extra count.
// - clear on A, set on A, clear on B gives free-running PWM.
// - trigger, clear on B, set A clear B gives one delayed pulse.
// - wrap from ff to 00 sets overflow flag; interrupt if enabled.
// - clear select 01 match A, 10 match B, 11 rising external clear.
// - with trigger enabled counting halts on clear, resumes on trigger edge.
// - trigger edge 00 off, 01 rising, 10 falling, 11 both.
`ifndef TIMER_V_REGS_VH
`define TIMER_V_REGS_VH

`define OFS_CTRL0        8'h00
`define OFS_CTRL1        8'h04
`define OFS_OUTSTAT      8'h08
`define OFS_CONST_A      8'h0c
`define OFS_CONST_B      8'h10
`define OFS_COUNTER      8'h14
`define OFS_IRQ_STATUS   8'h18
`define OFS_IRQ_MASK     8'h1c

// control_reg_zero fields
`define C0_CKS_LSB       0
`define C0_CCLR_LSB      3
`define C0_OVERFLOW_IRQ_ENABLE_BIT      5
// control_reg_one fields
`define C1_ICKS_BIT      0
`define C1_TRIGGER_ENABLE_BIT      2
`define C1_TVEG_LSB      3
`define C1_RESERVED      8'he2
// output_status_reg fields
`define OS_A_LSB         0
`define OS_B_LSB         2
`define OS_OVF_BIT       4
`define OS_MATCH_FLAG_A_BIT      6
`define OS_MATCH_FLAG_B_BIT      7

`define CLR_NONE         2'h0
`define CLR_MATCH_A      2'h1
`define CLR_MATCH_B      2'h2
`define CLR_EXT_PIN      2'h3

`define TRG_OFF          2'h0
`define TRG_RISE         2'h1
`define TRG_FALL         2'h2
`define TRG_BOTH         2'h3

`define OUT_KEEP         2'h0
`define OUT_ZERO         2'h1
`define OUT_ONE          2'h2
`define OUT_TOGGLE       2'h3

`define CONST_RESET      8'hff
`define IRQ_OVF_BIT      0
`define IRQ_CMA_BIT      1
`define IRQ_CMB_BIT      2

`endif

// ===== design/count_clock_select.v
// counter clock selection: prescaler taps or external clock, one count pulse
`timescale 1ns/1ps
`default_nettype none
`include "timer_v_regs.vh"
module count_clock_select #(
  parameter DIV_WIDTH = 13
) (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // selection
  input  wire [2:0] clock_select_field,
  input  wire       internal_clock_select,
  // external clock pin
  input  wire       ext_clock_pin,
  // count pulse
  output reg        count_pulse
);
  reg  [DIV_WIDTH-1:0] div_reg;
  reg                  src_reg;
  reg                  ext_reg;
  reg                  src_now;

  always @* begin
    // internal taps: 001 /2, 010 /16, 011 /256; 100..110 external edges; 000 and 111 stop;
    // internal_clock_select picks /4, /64 or /8192 within the pair instead
    case (clock_select_field)
      3'h1: src_now = internal_clock_select ? div_reg[1] : div_reg[0];
      3'h2: src_now = internal_clock_select ? div_reg[5] : div_reg[3];
      3'h3: src_now = internal_clock_select ? div_reg[12] : div_reg[7];
      3'h4: src_now = ext_reg;
      3'h5: src_now = ext_reg;
      3'h6: src_now = ext_reg;
      default: src_now = 1'b0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg     <= {DIV_WIDTH{1'b0}};
      src_reg     <= 1'b0;
      ext_reg     <= 1'b0;
      count_pulse <= 1'b0;
    end else begin
      div_reg <= div_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      ext_reg <= ext_clock_pin;
      src_reg <= src_now;
      // a source switch seen as a falling edge also counts
      case (clock_select_field)
        3'h4: count_pulse <= ~src_reg & src_now;
        3'h5: count_pulse <= src_reg & ~src_now;
        3'h6: count_pulse <= src_reg ^ src_now;
        3'h0: count_pulse <= 1'b0;
        3'h7: count_pulse <= 1'b0;
        default: count_pulse <= src_reg & ~src_now;
      endcase
    end
  end
endmodule // count_clock_select
`default_nettype wire

// ===== design/compare_match_pulse_timer.v
// 8-bit compare-match timer with pin output, trigger and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_v_regs.vh"
module compare_match_pulse_timer (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // pins
  input  wire        trigger_pin,
  input  wire        external_clear_pin,
  input  wire        ext_clock_pin,
  output reg         timer_output_pin,
  // interrupt
  output reg         irq
);
  reg  [7:0] up_counter_v;
  reg  [7:0] compare_const_a;
  reg  [7:0] compare_const_b;
  reg  [2:0] clock_select_field;
  reg  [1:0] clear_select;
  reg        overflow_irq_enable;
  reg        internal_clock_select;
  reg        trigger_enable;
  reg  [1:0] trigger_edge;
  reg  [3:0] output_action_select;
  reg        overflow_flag;
  reg        match_flag_a;
  reg        match_flag_b;
  reg  [2:0] irq_status_reg;
  reg  [2:0] irq_mask_reg;
  reg        halted_reg;
  reg        trig_reg;
  reg        clr_pin_reg;
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg  [7:0] addr_reg;
  wire       count_pulse;

  count_clock_select #(
    .DIV_WIDTH (13)
  ) u_clk (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .clock_select_field    (clock_select_field),
    .internal_clock_select (internal_clock_select),
    .ext_clock_pin         (ext_clock_pin),
    .count_pulse           (count_pulse)
  );

  // priority rank of one match given its two-bit action
  function [1:0] rank;
    input [1:0] act;
    begin
      case (act)
        `OUT_TOGGLE: rank = 2'h3;
        `OUT_ONE:    rank = 2'h2;
        `OUT_ZERO:   rank = 2'h1;
        default:     rank = 2'h0;
      endcase
    end
  endfunction

  // bus data phase is the write's third state
  wire       wr_now  = wr_pend_reg;
  wire       wr_cnt  = wr_now && addr_reg == `OFS_COUNTER;
  wire       wr_ca   = wr_now && addr_reg == `OFS_CONST_A;
  wire       wr_cb   = wr_now && addr_reg == `OFS_CONST_B;
  wire [7:0] wdat    = hwdata[7:0];

  // compare every cycle; suppressed while its constant is written
  wire match_a = (up_counter_v == compare_const_a) && !wr_ca;
  wire match_b = (up_counter_v == compare_const_b) && !wr_cb;

  // trigger edges
  wire trig_rise = trigger_pin && !trig_reg;
  wire trig_fall = !trigger_pin && trig_reg;
  reg  trig_hit;
  always @* begin
    case (trigger_edge)
      `TRG_RISE: trig_hit = trig_rise;
      `TRG_FALL: trig_hit = trig_fall;
      `TRG_BOTH: trig_hit = trig_rise | trig_fall;
      default:   trig_hit = 1'b0;
    endcase
  end

  // counter clear sources
  reg clear_now;
  always @* begin
    case (clear_select)
      `CLR_MATCH_A: clear_now = match_a;
      `CLR_MATCH_B: clear_now = match_b;
      `CLR_EXT_PIN: clear_now = external_clear_pin && !clr_pin_reg;
      default:      clear_now = 1'b0;
    endcase
  end

  wire running  = !(trigger_enable && halted_reg);
  wire step     = count_pulse && running;
  wire wrap     = step && up_counter_v == 8'hff && !clear_now && !wr_cnt;

  // counter: clear beats write, write beats count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_counter_v <= 8'h00;
    end else if (clear_now) begin
      up_counter_v <= 8'h00;
    end else if (wr_cnt) begin
      up_counter_v <= wdat;
    end else if (step) begin
      up_counter_v <= up_counter_v + 8'h01;
    end
  end

  // halt on clear with trigger enabled, resume on selected edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halted_reg <= 1'b0;
    end else if (!trigger_enable) begin
      halted_reg <= 1'b0;
    end else if (trig_hit) begin
      halted_reg <= 1'b0;
    end else if (clear_now) begin
      halted_reg <= 1'b1;
    end
  end

  // output pin with toggle > one > zero when both match
  wire [1:0] act_a = match_a ? output_action_select[1:0] : `OUT_KEEP;
  wire [1:0] act_b = match_b ? output_action_select[3:2] : `OUT_KEEP;
  wire [1:0] act   = (rank(act_a) >= rank(act_b)) ? act_a : act_b;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
    end else begin
      case (act)
        `OUT_TOGGLE: timer_output_pin <= ~timer_output_pin;
        `OUT_ONE:    timer_output_pin <= 1'b1;
        `OUT_ZERO:   timer_output_pin <= 1'b0;
        default:     timer_output_pin <= timer_output_pin;
      endcase
    end
  end

  // address phase capture; always zero wait states
  wire take = hsel && hready && htrans[1];
  wire rd_status = rd_pend_reg && addr_reg == `OFS_IRQ_STATUS;
  wire wr_os     = wr_now && addr_reg == `OFS_OUTSTAT;
  wire [2:0] ev  = {match_b, match_a, wrap};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      trig_reg    <= 1'b0;
      clr_pin_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        addr_reg <= haddr;
      end
      trig_reg    <= trigger_pin;
      clr_pin_reg <= external_clear_pin;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // control registers and flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_const_a       <= `CONST_RESET;
      compare_const_b       <= `CONST_RESET;
      clock_select_field    <= 3'h0;
      clear_select          <= `CLR_NONE;
      overflow_irq_enable   <= 1'b0;
      internal_clock_select <= 1'b0;
      trigger_enable        <= 1'b0;
      trigger_edge          <= `TRG_OFF;
      output_action_select  <= 4'h0;
      overflow_flag         <= 1'b0;
      match_flag_a          <= 1'b0;
      match_flag_b          <= 1'b0;
      irq_status_reg        <= 3'h0;
      irq_mask_reg          <= 3'h0;
    end else begin
      if (wr_ca) compare_const_a <= wdat;
      if (wr_cb) compare_const_b <= wdat;
      if (wr_now && addr_reg == `OFS_CTRL0) begin
        clock_select_field  <= wdat[`C0_CKS_LSB+2:`C0_CKS_LSB];
        clear_select        <= wdat[`C0_CCLR_LSB+1:`C0_CCLR_LSB];
        overflow_irq_enable <= wdat[`C0_OVERFLOW_IRQ_ENABLE_BIT];
      end
      if (wr_now && addr_reg == `OFS_CTRL1) begin
        internal_clock_select <= wdat[`C1_ICKS_BIT];
        trigger_enable        <= wdat[`C1_TRIGGER_ENABLE_BIT];
        trigger_edge          <= wdat[`C1_TVEG_LSB+1:`C1_TVEG_LSB];
      end
      if (wr_os) begin
        output_action_select <= wdat[3:0];
      end
      // flags: writing 0 clears, an event in that cycle wins
      overflow_flag <= wrap | (overflow_flag &
        ~(wr_os & ~wdat[`OS_OVF_BIT]));
      match_flag_a <= match_a | (match_flag_a &
        ~(wr_os & ~wdat[`OS_MATCH_FLAG_A_BIT]));
      match_flag_b <= match_b | (match_flag_b &
        ~(wr_os & ~wdat[`OS_MATCH_FLAG_B_BIT]));
      if (wr_now && addr_reg == `OFS_IRQ_MASK) begin
        irq_mask_reg <= wdat[2:0];
      end
      irq_status_reg <= ev | (irq_status_reg & {3{~rd_status}});
    end
  end

  // read mux, registered on the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      irq    <= 1'b0;
    end else begin
      // overflow reaches the pin only with its enable set
      irq <= |(irq_status_reg & irq_mask_reg &
        {2'h3, overflow_irq_enable});
      hrdata <= 32'h0000_0000;
      if (take && !hwrite) begin
        case (haddr)
          `OFS_CTRL0: hrdata <= {26'h0, overflow_irq_enable,
            clear_select, clock_select_field};
          `OFS_CTRL1: hrdata <= {24'h0, `C1_RESERVED | {3'h0,
            trigger_edge, trigger_enable, 1'b0, internal_clock_select}};
          `OFS_OUTSTAT: hrdata <= {24'h0, match_flag_b, match_flag_a,
            1'b0, overflow_flag, output_action_select};
          `OFS_CONST_A: hrdata <= {24'h0, compare_const_a};
          `OFS_CONST_B: hrdata <= {24'h0, compare_const_b};
          `OFS_COUNTER: hrdata <= {24'h0, up_counter_v};
          `OFS_IRQ_STATUS: hrdata <= {29'h0, irq_status_reg};
          `OFS_IRQ_MASK: hrdata <= {29'h0, irq_mask_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // compare_match_pulse_timer
`default_nettype wire

// ===== sim/timer_pins_model.sv
// partner model driving the trigger, clear and external clock pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  // clock
  input  wire logic hclk,
  // bench requests
  input  wire logic clk_run,
  input  wire logic trig_lvl,
  input  wire logic clr_lvl,
  // pins
  output logic      trigger_pin,
  output logic      external_clear_pin,
  output logic      ext_clock_pin
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    {trigger_pin, external_clear_pin, ext_clock_pin} = 3'h0;
  end
  // external clock runs at a quarter of hclk and stands low when stopped
  always @(posedge hclk) begin
    div_q <= clk_run ? div_q + 2'h1 : 2'h0;
    ext_clock_pin <= clk_run & div_q[1];
    trigger_pin <= trig_lvl;
    external_clear_pin <= clr_lvl;
  end
endmodule // pin_driver
`default_nettype wire

// ===== sim/timer_assertions.sv
// checker of the compare timer bus answers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "timer_v_regs.vh"
module timer_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupt
  input wire logic        irq
);
  logic       rd_q, wr_q, pw_q;
  logic [7:0] a_q, ca_q, mk_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rd_q, wr_q, pw_q, a_q, mk_q} <= '0;
      ca_q <= `CONST_RESET;
    end else begin
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      wr_q <= hsel & hready & htrans[1] & hwrite;
      pw_q <= wr_q;
      if (hsel & hready & htrans[1]) a_q <= haddr;
      if (wr_q && a_q == `OFS_CONST_A) ca_q <= hwdata[7:0];
      if (wr_q && a_q == `OFS_IRQ_MASK) mk_q <= hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_rdata_byte: assert property (rd_q |-> hrdata[31:8] == 24'h0)
    else $error("upper read bytes set");
  a_ctrl1_ones: assert property (rd_q && a_q == `OFS_CTRL1 |->
    hrdata[7:5] == 3'h7 && hrdata[1]) else $error("reserved bits");
  a_unmapped_zero: assert property (rd_q && a_q > `OFS_IRQ_MASK |->
    hrdata == 32'h0) else $error("unmapped read");
  a_const_read: assert property (rd_q && !pw_q &&
    a_q == `OFS_CONST_A |-> hrdata[7:0] == ca_q) else $error("const a");
  a_irq_masked: assert property ((mk_q[2:0] == 3'h0) [*2] |-> !irq)
    else $error("masked irq");
endmodule // timer_chk
bind compare_match_pulse_timer timer_chk timer_chk_i (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
  .hreadyout, .hresp, .irq);
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench of the compare timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_v_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %0t mismatch", $time); end end
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, clk_run, trig_lvl, clr_lvl;
  logic [7:0]  haddr, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        hreadyout, hresp, timer_output_pin, irq;
  logic        trigger_pin, external_clear_pin, ext_clock_pin;
  wire         hready;
  int          n_fail, num_checks, a, b, p1, h1, p2, h2, n_rise, n;
  assign hready = hreadyout;
  compare_match_pulse_timer compare_match_pulse_timer_i (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .trigger_pin, .external_clear_pin, .ext_clock_pin,
    .timer_output_pin, .irq);
  pin_driver pin_driver_i (.hclk, .clk_run, .trig_lvl, .clr_lvl,
    .trigger_pin, .external_clear_pin, .ext_clock_pin);
  always @(posedge timer_output_pin) n_rise++;
  task end_sim;
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] ad, input int wd);
    hsel <= 1'b1; hwrite <= w; haddr <= ad; htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, 8'(wd)};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  // cycles from one output rise to the next, and high cycles within
  task automatic meas(output int p, output int h);
    logic q;
    q = 1'b1; p = 0; h = 0;
    @(posedge timer_output_pin);
    forever begin
      @(negedge hclk);
      if (timer_output_pin && !q) break;
      p++; h += timer_output_pin; q = timer_output_pin;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    #1000000 n_fail++;
    end_sim;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, clk_run, trig_lvl, clr_lvl} = '0;
    {hresetn, n_fail, num_checks, n_rise} = '0;
    hsize = 3'h2;
    void'($urandom(93091));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, `OFS_CONST_B, 0); `CHK(rd, `CONST_RESET)
    xfer(0, `OFS_CTRL1, 0); `CHK(rd, `C1_RESERVED)
    xfer(0, 8'h40, 0); `CHK(rd, 8'h00)
    for (int i = 0; i < 4; i++) begin
      a = $urandom_range(255);
      xfer(1, `OFS_COUNTER, a); xfer(0, `OFS_COUNTER, 0);
      `CHK(rd, 8'(a))
      xfer(1, `OFS_CONST_A, a); xfer(0, `OFS_CONST_A, 0);
      `CHK(rd, 8'(a))
    end
    // free-running pwm: period tracks a, high time tracks b
    a = $urandom_range(12, 8); b = $urandom_range(6, 2);
    xfer(1, `OFS_CONST_A, a); xfer(1, `OFS_CONST_B, b);
    xfer(1, `OFS_OUTSTAT, 8'h06); xfer(1, `OFS_CTRL0, 8'h0c);
    clk_run <= 1'b1;
    meas(p1, h1); meas(p1, h1);
    xfer(1, `OFS_CONST_A, a + 4); xfer(1, `OFS_CONST_B, b + 3);
    meas(p2, h2); meas(p2, h2);
    `CHK(p2 - p1, 16)
    `CHK(h2 - h1, 12)
    // triggered one-shot for every edge selection
    xfer(1, `OFS_CONST_A, 3); xfer(1, `OFS_CONST_B, 8);
    xfer(1, `OFS_CTRL0, 8'h14);
    for (int tv = 0; tv < 4; tv++) begin
      xfer(1, `OFS_CTRL1, 8'h04 | (tv << 3));
      repeat (1100) @(posedge hclk);
      n = n_rise;
      trig_lvl <= 1'b1;
      repeat (100) @(posedge hclk);
      trig_lvl <= 1'b0;
      repeat (100) @(posedge hclk);
      `CHK(n_rise - n, tv == 0 ? 0 : (tv == 3 ? 2 : 1))
    end
    // rising edge of the clear pin empties the counter
    xfer(1, `OFS_CTRL1, 0); xfer(1, `OFS_CTRL0, 8'h1c);
    xfer(1, `OFS_COUNTER, 8'h50);
    clr_lvl <= 1'b1;
    repeat (4) @(posedge hclk);
    clr_lvl <= 1'b0;
    xfer(0, `OFS_COUNTER, 0); `CHK(rd < 8'h08, 1'b1)
    // overflow interrupt, unmasked then masked
    xfer(1, `OFS_CTRL0, 8'h24); xfer(1, `OFS_IRQ_MASK, 1);
    for (int m = 1; m >= 0; m--) begin
      xfer(1, `OFS_IRQ_MASK, m); xfer(1, `OFS_COUNTER, 8'hf0);
      xfer(0, `OFS_IRQ_STATUS, 0);
      repeat (100) @(posedge hclk);
      @(negedge hclk); `CHK(irq, 1'(m))
      xfer(0, `OFS_IRQ_STATUS, 0); `CHK(rd[0], 1'b1)
      @(posedge hclk);
      @(negedge hclk); `CHK(irq, 1'b0)
    end
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
